/* bench/nfe_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

// host end of the serial port: takes bytes, stalling three cycles in four when slow
module nfe_host_model (
	input  wire logic       mclk,
	input  wire logic       slow,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready = 1'b0
);
	logic [7:0] got[$];
	logic [1:0] cnt_reg = 2'h0;

	// stall pattern and byte capture on each accepted edge
	always @(posedge mclk)
	begin
		cnt_reg <= cnt_reg + 2'h1;
		tx_ready <= !slow || (cnt_reg == 2'h0);
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
	end
endmodule : nfe_host_model

`default_nettype wire

/* bench/node_ident_frame_emitter_bench.sv */
`timescale 1ns/100ps
`default_nettype none

module node_ident_frame_emitter_bench;
	import nfe_pkg::*;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic        rx_valid = 1'b0;
	nfe_rx_t     rx_frame = '0;
	logic        rx_ready, tx_valid, tx_ready, ident_tx_req, assoc_led;
	logic [7:0]  tx_data;
	logic        commission_button = 1'b0;
	logic        sync_wait_active = 1'b0;
	logic        slow = 1'b0;
	logic [7:0]  exp_q[$];
	int          errors = 0;
	int          checks_done = 0;

	always #10 mclk = ~mclk;

	nfe_frame_emitter #(.SYNC_WAIT_CYC(20), .LED_FLASH_CYC(8)) dut (
		.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
		.rx_frame(rx_frame), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready), .commission_button(commission_button),
		.sync_wait_active(sync_wait_active), .ident_tx_req(ident_tx_req), .assoc_led(assoc_led)
	);

	nfe_host_model host (.mclk(mclk), .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready));

	task automatic end_sim;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd

	// push n bytes of v, most significant first
	task automatic add(input logic [63:0] v, input int n);
		for (int k = n - 1; k >= 0; k--)
			exp_q.push_back(v[8*k+:8]);
	endtask : add

	// expected frame worked out field by field
	task automatic build(input nfe_rx_t r, input logic t, input logic s);
		logic [7:0]  sum;
		logic [15:0] len;
		len = 16'd31 + 16'(r.name_len) + (t ? 16'd4 : 16'd0) + (s ? 16'd1 : 16'd0);
		exp_q = {8'h7e, len[15:8], len[7:0], 8'h95};
		add(r.src_addr, 8);
		// an invalid method code goes out as point-multipoint
		add({16'hfffe, (r.method == 2'b00) ? METH_PMP_C : r.method, 4'h0, r.bcast, r.acked, 16'hfffe}, 5);
		add(r.rem_addr, 8);
		for (int k = 0; k < r.name_len; k++)
			exp_q.push_back(r.name[8*k+:8]);
		add({8'h00, 16'hfffe, r.role, r.event_code}, 5);
		add({PROFILE_CODE_C, MAKER_CODE_C}, 4);
		if (t)
			add(r.kind_tag, 4);
		if (s)
			add(r.rssi, 1);
		sum = 8'h00;
		for (int i = 3; i < exp_q.size(); i++)
			sum += exp_q[i];
		exp_q.push_back(8'hff - sum);
	endtask : build

	task automatic frame_case(input logic t, input logic s, input logic sl, input int nl, input logic [1:0] m);
		nfe_rx_t r;
		int      n;
		wr(ADDR_CTRL_C, {30'h0, s, t});
		r = '0;
		r.src_addr = 64'h0011_2233_4455_6677;
		r.rem_addr = 64'h8899_aabb_ccdd_eeff;
		r.acked = sl;
		r.bcast = !sl;
		r.method = m;
		r.name_len = 8'(nl);
		for (int k = 0; k < nl; k++)
			r.name[8*k+:8] = 8'h41 + 8'(k);
		r.role = 8'h01;
		r.event_code = 8'h01;
		r.kind_tag = 32'h1234_5678;
		r.rssi = 8'h2d;
		build(r, t, s);
		host.got.delete();
		@(posedge mclk);
		slow <= sl;
		rx_frame <= r;
		rx_valid <= 1'b1;
		n = 0;
		@(negedge mclk);
		while (!rx_ready)
		begin
			if (++n > 20)
			begin
				errors++;
				end_sim();
			end
			@(negedge mclk);
		end
		@(posedge mclk);
		rx_valid <= 1'b0;
		#1;
		chk("assoc_led on", 1, assoc_led);
		chk("rx_ready busy", 0, rx_ready);
		n = 0;
		while (host.got.size() < exp_q.size())
		begin
			if (++n > 600)
			begin
				errors++;
				end_sim();
			end
			@(posedge mclk);
			#1;
		end
		@(posedge mclk);
		#1;
		chk("tx_valid idle", 0, tx_valid);
		chk("assoc_led off", 0, assoc_led);
		chk("frame size", exp_q.size(), host.got.size());
		chk("frame type", 8'h95, host.got[3]);
		chk("method bits", {((m == 2'b00) ? METH_PMP_C : m), 6'h0}, host.got[14] & 8'hc0);
		chk("checksum", exp_q[exp_q.size()-1], host.got[host.got.size()-1]);
		for (int i = 0; i < exp_q.size(); i++)
			chk("frame byte", exp_q[i], host.got[i]);
	endtask : frame_case

	// four frames: plain, tag and rssi under stalls, tag with longest name, tag with method code 00
	task automatic test_frames;
		frame_case(1'b0, 1'b0, 1'b0, 4, METH_MESH_C);
		frame_case(1'b1, 1'b1, 1'b1, 2, METH_PMP_C);
		frame_case(1'b1, 1'b0, 1'b0, NAME_MAX_C, METH_DBC_C);
		frame_case(1'b1, 1'b0, 1'b0, 3, 2'b00);
	endtask : test_frames

	task automatic test_ident;
		int cnt;
		int first;
		wr(ADDR_CMD_C, CMD_IDENT_C);
		#1 chk("cmd ident", 1, ident_tx_req);
		@(posedge mclk);
		#1 chk("ident one cycle", 0, ident_tx_req);
		@(posedge mclk);
		commission_button <= 1'b1;
		@(posedge mclk);
		#1 chk("button ident", 1, ident_tx_req);
		@(posedge mclk);
		commission_button <= 1'b0;
		sync_wait_active <= 1'b1;
		cnt = 0;
		first = 0;
		for (int i = 1; i <= 40; i++)
		begin
			@(posedge mclk);
			#1;
			if (ident_tx_req === 1'b1)
			begin
				cnt++;
				first = i;
			end
		end
		chk("sync pulses", 1, cnt);
		chk("sync delay", 20, first);
		@(posedge mclk);
		sync_wait_active <= 1'b0;
	endtask : test_ident

	task automatic test_regs;
		logic [31:0] v;
		rd(ADDR_STAT_C, v);
		chk("frames sent", 4, v[15:8]);
		rd(ADDR_CTRL_C, v);
		chk("ctrl readback", 1, v);
		rd(4'hc, v);
		chk("unmapped read", 0, v);
	endtask : test_regs

	initial
	begin
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		#1;
		chk("rx_ready reset", 1, rx_ready);
		chk("tx_valid reset", 0, tx_valid);
		test_frames();
		test_regs();
		test_ident();
		end_sim();
	end
endmodule : node_ident_frame_emitter_bench

`default_nettype wire

/* core/nfe_frame_emitter.sv */
// What this block does
// R1: emit indicator frame per received identification broadcast
// R2: frame type byte 0x95 at offset 3
// R3: 16-bit length counts bytes between length field and checksum
// R4: sender 64-bit address at offset 4
// R5: reserved fields carry 0xfffe
// R6: options bit0 acked, bit1 broadcast, reserved zero
// R7: delivery method bits never 00
// R8: originator 64-bit address at offset 17
// R9: null-terminated name from offset 25, min one name byte
// R10: network role byte after trailing reserved field
// R11: source event byte follows network role
// R12: fixed profile then maker codes
// R13: device kind tag only when enabled
// R14: signal strength byte before checksum when enabled
// R15: checksum is 0xff minus sum from offset 3
// R16: identify on button press or command one
// R17: identify after thirty seconds awaiting sync
// R18: flash association indicator on each reception
// R19: ascending offsets, multi-byte fields msb first
`timescale 1ns/100ps
`default_nettype none

module nfe_frame_emitter #(
	parameter int unsigned SYNC_WAIT_CYC = 32'(nfe_pkg::SYNC_WAIT_CYC_C),
	parameter int unsigned LED_FLASH_CYC = 32'(nfe_pkg::LED_FLASH_CYC_C)
) (
	input  wire logic           mclk,
	input  wire logic           rst_n,
	input  wire logic [3:0]     reg_addr,
	input  wire logic [31:0]    reg_wdata,
	input  wire logic           reg_wr,
	input  wire logic           reg_rd,
	output logic      [31:0]    reg_rdata,
	input  wire logic           rx_valid,
	input  wire nfe_pkg::nfe_rx_t rx_frame,
	output logic                rx_ready,
	output logic                tx_valid,
	output logic      [7:0]     tx_data,
	input  wire logic           tx_ready,
	input  wire logic           commission_button,
	input  wire logic           sync_wait_active,
	output logic                ident_tx_req,
	output logic                assoc_led
);
	import nfe_pkg::*;

	initial
	begin
		if (SYNC_WAIT_CYC < 2 || LED_FLASH_CYC < 2)
			$error("nfe_frame_emitter: wait counts must be at least two");
	end

	typedef struct packed {
		nfe_fsm_t    fsm;
		nfe_rx_t     rx;
		logic        fr_tag;
		logic        fr_rssi;
		logic [7:0]  pos;
		logic [7:0]  last;
		logic [7:0]  data;
		logic [7:0]  sum;
		logic        tag_en;
		logic        rssi_en;
		logic [31:0] rdata;
		logic [7:0]  frames;
		logic [31:0] led_cnt;
		logic        led;
		logic [31:0] sync_cnt;
		logic        sync_done;
		logic        btn_prev;
		logic        ident;
	} nfe_state_t;

	nfe_state_t state_reg;
	nfe_state_t state_next;

	// byte count between length field and checksum
	function automatic logic [15:0] frame_len(input logic [7:0] n, input logic tag, input logic rssi);
		frame_len = 16'(n) + LEN_BASE_C + (tag ? LEN_TAG_C : 16'd0) + (rssi ? LEN_RSSI_C : 16'd0); // [R3]
	endfunction : frame_len

	// content byte at a given frame offset, checksum excluded
	function automatic logic [7:0] byte_at(input nfe_state_t s, input logic [7:0] p);
		logic [15:0] len;
		logic [7:0]  n;
		logic [7:0]  r;
		logic [7:0]  b;
		len = frame_len(s.rx.name_len, s.fr_tag, s.fr_rssi);
		n = s.rx.name_len;
		r = p - n - TRAIL_BASE_C;
		b = 8'h00;
		if (p == 8'd0)
			b = START_DELIM_C;
		else if (p == POS_LEN_HI_C)
			b = len[15:8]; // [R3] [R19]
		else if (p == POS_LEN_LO_C)
			b = len[7:0];
		else if (p == POS_TYPE_C)
			b = FRAME_TYPE_C; // [R2]
		else if (p < POS_RES1_C)
			b = 8'(s.rx.src_addr >> {8'(POS_RES1_C - 8'd1 - p), 3'b000}); // [R4] [R19]
		else if (p == POS_RES1_C || p == POS_RES2_C)
			b = RESERVED_C[15:8]; // [R5]
		else if (p == POS_RES1_C + 8'd1 || p == POS_RES2_C + 8'd1)
			b = RESERVED_C[7:0];
		else if (p == POS_OPT_C)
			b = {s.rx.method, 4'b0000, s.rx.bcast, s.rx.acked}; // [R6] [R7]
		else if (p < POS_NAME_C)
			b = 8'(s.rx.rem_addr >> {8'(POS_NAME_C - 8'd1 - p), 3'b000}); // [R8] [R19]
		else if (p < POS_NAME_C + n)
			b = 8'(s.rx.name >> {8'(p - POS_NAME_C), 3'b000}); // [R9]
		else if (p == POS_NAME_C + n)
			b = NAME_TERM_C; // [R9]
		else
		begin
			case (r)
				8'd0:    b = RESERVED_C[15:8]; // [R5]
				8'd1:    b = RESERVED_C[7:0];
				8'd2:    b = s.rx.role; // [R10]
				8'd3:    b = s.rx.event_code; // [R11]
				8'd4:    b = PROFILE_CODE_C[15:8]; // [R12]
				8'd5:    b = PROFILE_CODE_C[7:0];
				8'd6:    b = MAKER_CODE_C[15:8];
				8'd7:    b = MAKER_CODE_C[7:0];
				default:
				begin
					if (s.fr_tag && r < 8'd12)
						b = 8'(s.rx.kind_tag >> {8'(8'd11 - r), 3'b000}); // [R13] [R19]
					else if (s.fr_rssi)
						b = s.rx.rssi; // [R14]
					else
						b = 8'h00;
				end
			endcase
		end
		byte_at = b;
	endfunction : byte_at

	// next-state logic for bus, triggers, indicator and framer
	always_comb
	begin
		logic [7:0]  sum_n;
		logic [15:0] len;
		nfe_rx_t     rx_fix;
		sum_n = 8'h00;
		len = 16'h0000;
		rx_fix = rx_frame;
		state_next = state_reg;
		state_next.ident = 1'b0;
		state_next.btn_prev = commission_button;
		state_next.rdata = 32'h0000_0000;

		// register writes
		if (reg_wr)
		begin
			case (reg_addr)
				ADDR_CTRL_C:
				begin
					state_next.tag_en = reg_wdata[CTRL_TAG_BIT_C];
					state_next.rssi_en = reg_wdata[CTRL_RSSI_BIT_C];
				end
				ADDR_CMD_C:
					if (reg_wdata == CMD_IDENT_C)
						state_next.ident = 1'b1; // [R16]
				default:
					state_next.ident = state_next.ident;
			endcase
		end

		// register reads, data valid in the following cycle only
		if (reg_rd)
		begin
			case (reg_addr)
				ADDR_CTRL_C: state_next.rdata = {30'h0, state_reg.rssi_en, state_reg.tag_en};
				ADDR_STAT_C: state_next.rdata = {16'h0, state_reg.frames, 6'h0, state_reg.led,
					state_reg.fsm == FSM_SEND};
				default:     state_next.rdata = 32'h0000_0000;
			endcase
		end

		// single button press identifies this node
		if (commission_button && !state_reg.btn_prev)
			state_next.ident = 1'b1; // [R16]

		// sleep node awake too long waiting for sync identifies itself once
		if (sync_wait_active)
		begin
			if (!state_reg.sync_done)
			begin
				state_next.sync_cnt = state_reg.sync_cnt + 32'd1;
				if (state_reg.sync_cnt == SYNC_WAIT_CYC - 32'd1)
				begin
					state_next.ident = 1'b1; // [R17]
					state_next.sync_done = 1'b1;
				end
			end
		end
		else
		begin
			state_next.sync_cnt = 32'h0;
			state_next.sync_done = 1'b0;
		end

		// indicator hold timer
		if (state_reg.led_cnt != 32'h0)
			state_next.led_cnt = state_reg.led_cnt - 32'd1;
		else
			state_next.led = 1'b0;

		// framer
		case (state_reg.fsm)
			FSM_IDLE:
			begin
				if (rx_valid)
				begin
					if (rx_fix.method == 2'b00)
						rx_fix.method = METH_PMP_C; // [R7]
					if (rx_fix.name_len == 8'd0)
						rx_fix.name_len = 8'd1; // [R9]
					else if (rx_fix.name_len > 8'(NAME_MAX_C))
						rx_fix.name_len = 8'(NAME_MAX_C);
					len = frame_len(rx_fix.name_len, state_reg.tag_en, state_reg.rssi_en);
					state_next.rx = rx_fix; // [R1]
					state_next.fr_tag = state_reg.tag_en; // [R13]
					state_next.fr_rssi = state_reg.rssi_en; // [R14]
					state_next.pos = 8'd0;
					state_next.last = POS_TYPE_C + len[7:0];
					state_next.data = START_DELIM_C;
					state_next.sum = 8'h00;
					state_next.fsm = FSM_SEND;
					state_next.led = 1'b1; // [R18]
					state_next.led_cnt = LED_FLASH_CYC - 32'd1;
				end
			end
			FSM_SEND:
			begin
				if (tx_ready)
				begin
					if (state_reg.pos == state_reg.last)
					begin
						state_next.fsm = FSM_IDLE;
						state_next.frames = state_reg.frames + 8'd1;
					end
					else
					begin
						sum_n = (state_reg.pos >= POS_TYPE_C) ? state_reg.sum + state_reg.data : state_reg.sum;
						state_next.sum = sum_n;
						state_next.pos = state_reg.pos + 8'd1; // [R19]
						if (state_reg.pos + 8'd1 == state_reg.last)
							state_next.data = CKSUM_BASE_C - sum_n; // [R15]
						else
							state_next.data = byte_at(state_reg, state_reg.pos + 8'd1);
					end
				end
			end
			default:
				state_next.fsm = FSM_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			state_reg <= '0;
			state_reg.fsm <= FSM_IDLE;
		end
		else
			state_reg <= state_next;
	end

	// port drive
	assign rx_ready = state_reg.fsm == FSM_IDLE;
	assign tx_valid = state_reg.fsm == FSM_SEND;
	assign tx_data = state_reg.data;
	assign reg_rdata = state_reg.rdata;
	assign ident_tx_req = state_reg.ident;
	assign assoc_led = state_reg.led;

	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	logic fire;
	assign fire = tx_valid && tx_ready;

	start_delim_a: assert property (rx_valid && rx_ready |=> tx_valid && tx_data == START_DELIM_C) // [R1]
		else $error("frame does not open with start delimiter");
	frame_type_a: assert property (tx_valid && state_reg.pos == POS_TYPE_C |-> tx_data == FRAME_TYPE_C) // [R2]
		else $error("frame type byte wrong");
	length_field_a: assert property (tx_valid && state_reg.pos == POS_LEN_LO_C |-> tx_data == 8'(state_reg.last - POS_TYPE_C)) // [R3]
		else $error("length low byte disagrees with frame end");
	reserved_word_a: assert property (fire && state_reg.pos == POS_RES1_C |=> tx_data == RESERVED_C[7:0]) // [R5]
		else $error("reserved field not fffe");
	option_bits_a: assert property (tx_valid && state_reg.pos == POS_OPT_C |-> tx_data[7:6] != 2'b00 && tx_data[5:2] == 4'h0) // [R6] [R7]
		else $error("options byte malformed");
	checksum_value_a: assert property (tx_valid && state_reg.pos == state_reg.last |-> 8'(tx_data + state_reg.sum) == CKSUM_BASE_C) // [R15]
		else $error("checksum byte wrong");
	offset_order_a: assert property (fire && state_reg.pos != state_reg.last |=> tx_valid && state_reg.pos == $past(state_reg.pos) + 8'd1) // [R19]
		else $error("offsets not ascending by one");
	ident_cmd_a: assert property (reg_wr && reg_addr == ADDR_CMD_C && reg_wdata == CMD_IDENT_C |=> ident_tx_req) // [R16]
		else $error("identify command did not raise request");
	button_ident_a: assert property ($rose(commission_button) |=> ident_tx_req) // [R16]
		else $error("button press did not raise request");
	led_flash_a: assert property (rx_valid && rx_ready |=> assoc_led [*2]) // [R18]
		else $error("association indicator not flashed");

	tagged_frame_c: cover property (rx_valid && rx_ready && state_reg.tag_en && state_reg.rssi_en ##[1:80] fire && state_reg.pos == state_reg.last);
	plain_frame_c: cover property (rx_valid && rx_ready && !state_reg.tag_en ##[1:80] fire && state_reg.pos == state_reg.last);
	stall_c: cover property (tx_valid && !tx_ready ##1 fire);
	sync_ident_c: cover property (sync_wait_active && state_reg.sync_cnt == SYNC_WAIT_CYC - 32'd1 ##1 ident_tx_req);

endmodule : nfe_frame_emitter

`default_nettype wire

/* core/nfe_pkg.sv */
package nfe_pkg;

	// serial frame layout
	localparam logic [7:0]  START_DELIM_C   = 8'h7e;
	localparam logic [7:0]  FRAME_TYPE_C    = 8'h95;
	localparam logic [15:0] RESERVED_C      = 16'hfffe;
	localparam logic [7:0]  NAME_TERM_C     = 8'h00;
	localparam logic [7:0]  CKSUM_BASE_C    = 8'hff;
	localparam logic [7:0]  POS_LEN_HI_C    = 8'd1;
	localparam logic [7:0]  POS_LEN_LO_C    = 8'd2;
	localparam logic [7:0]  POS_TYPE_C      = 8'd3;
	localparam logic [7:0]  POS_SRC_C       = 8'd4;
	localparam logic [7:0]  POS_RES1_C      = 8'd12;
	localparam logic [7:0]  POS_OPT_C       = 8'd14;
	localparam logic [7:0]  POS_RES2_C      = 8'd15;
	localparam logic [7:0]  POS_REM_C       = 8'd17;
	localparam logic [7:0]  POS_NAME_C      = 8'd25;
	localparam logic [7:0]  TRAIL_BASE_C    = 8'd26;
	localparam logic [15:0] LEN_BASE_C      = 16'd31;
	localparam logic [15:0] LEN_TAG_C       = 16'd4;
	localparam logic [15:0] LEN_RSSI_C      = 16'd1;
	localparam int          NAME_MAX_C      = 20;

	// fixed profile and maker codes; values are arbitrary
	localparam logic [15:0] PROFILE_CODE_C  = 16'h0a01;
	localparam logic [15:0] MAKER_CODE_C    = 16'h0b02;

	// delivery method encodings of option bits 7:6
	localparam logic [1:0]  METH_PMP_C      = 2'b01;
	localparam logic [1:0]  METH_DBC_C      = 2'b10;
	localparam logic [1:0]  METH_MESH_C     = 2'b11;

	// register map
	localparam logic [3:0]  ADDR_CTRL_C     = 4'h0;
	localparam logic [3:0]  ADDR_CMD_C      = 4'h4;
	localparam logic [3:0]  ADDR_STAT_C     = 4'h8;
	localparam int          CTRL_TAG_BIT_C  = 0;
	localparam int          CTRL_RSSI_BIT_C = 1;
	localparam logic [31:0] CMD_IDENT_C     = 32'h0000_0001;

	// timing
	localparam longint      CLK_HZ_C        = 50_000_000;
	localparam longint      SYNC_WAIT_S_C   = 30;
	localparam longint      LED_FLASH_MS_C  = 200;
	localparam longint      SYNC_WAIT_CYC_C = SYNC_WAIT_S_C * CLK_HZ_C;
	localparam longint      LED_FLASH_CYC_C = (LED_FLASH_MS_C * CLK_HZ_C) / 1000;

	typedef enum logic [1:0] {
		FSM_IDLE = 2'b01,
		FSM_SEND = 2'b10
	} nfe_fsm_t;

	// one received identification broadcast
	typedef struct packed {
		logic [63:0]             src_addr;
		logic [63:0]             rem_addr;
		logic                    acked;
		logic                    bcast;
		logic [1:0]              method;
		logic [NAME_MAX_C*8-1:0] name;
		logic [7:0]              name_len;
		logic [7:0]              role;
		logic [7:0]              event_code;
		logic [31:0]             kind_tag;
		logic [7:0]              rssi;
	} nfe_rx_t;

endpackage : nfe_pkg
